// ===== core/ccp_config_pins.sv
/*
 * configuration-control pin logic: mode capture, byte-accept flag, read strobe,
 * loading indicator, scan gating and hand-over of pins to user i/o.
 * assumes all inputs synchronous to clk_sys; loader core supplies busy and done.
 */
`timescale 1ns/1ps
`include "ccp_map.svh"

module ccp_config_pins #(
	parameter int MODE_W = `CCP_MODE_W // mode select width
) (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // synchronous reset, active high
	input wire logic reload_request_n, // restart request, active low
	input wire logic startup_gate, // init gate; mode captured on its rise
	input wire logic [MODE_W-1:0] mode_pins, // mode select pins
	input wire logic load_done, // loader finished configuration
	input wire logic loader_busy, // loader cannot accept a byte
	input wire logic mem_read_req, // loader wants a byte from memory
	input wire logic host_sel, // device selected by host
	input wire logic host_rd, // host read strobe
	input wire logic scan_selected, // boundary scan kept after loading
	input wire logic host_port_used, // host port kept after loading
	input wire logic test_clk, // scan test clock pin
	input wire logic test_mode_sel, // scan test mode select pin
	input wire logic [3:0] user_out, // user data for flag, loading, strobe; bit 3 unused
	input wire logic [3:0] user_oe_n, // user enables for those pins, active low
	output logic [MODE_W-1:0] cfg_mode, // captured configuration mode
	output logic scan_enable, // boundary-scan functions allowed
	output logic scan_reset, // boundary-scan circuitry reset
	output logic load_restart, // restart pulse to loader
	output logic byte_accept_o, // byte-accept flag pin output
	output logic byte_accept_oe_n, // byte-accept pin enable, active low
	output logic [`CCP_DATA_W-1:0] host_rd_data, // status byte to host
	output logic high_while_loading_o, // loading indicator output
	output logic high_while_loading_oe_n, // loading indicator enable, active low
	output logic rd_strobe_o, // memory read strobe pin output
	output logic rd_strobe_oe_n, // memory read strobe enable, active low
	output logic pins_user, // mode pins, and scan pins unless scan kept, handed to user
	output logic scan_inputs_bad // scan unused yet neither tck nor tms high
);
	typedef struct packed {
		ccp_pkg::ccp_phase_t phase;
		logic gate_d;
		logic [MODE_W-1:0] mode;
		logic scan_en;
		logic scan_rst;
		logic restart;
		logic ba_o;
		logic ba_oe_n;
		logic [`CCP_DATA_W-1:0] rd_data;
		logic hwl_o;
		logic hwl_oe_n;
		logic rs_o;
		logic rs_oe_n;
		logic user;
		logic scan_bad;
	} ccp_state_t;

	ccp_state_t st_r, st_nxt;
	logic strobe_n;
	logic master_par;

	function automatic logic is_periph(input logic [MODE_W-1:0] m);
		is_periph = (m == MODE_W'(`CCP_MODE_PERIPH_SYNC)) ||
			(m == MODE_W'(`CCP_MODE_PERIPH_ASYNC));
	endfunction : is_periph

	assign master_par = (st_r.phase == ccp_pkg::CCP_CONFIG) &&
		(st_r.mode == MODE_W'(`CCP_MODE_MASTER_PAR));

	ccp_rd_strobe u_rd_strobe (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.enable(master_par),
		.req(mem_read_req),
		.rd_strobe_n(strobe_n)
	);

	always_comb begin
		st_nxt = st_r;
		st_nxt.gate_d = startup_gate;
		st_nxt.restart = 1'b0;
		st_nxt.scan_rst = 1'b0;
		case (st_r.phase)
			ccp_pkg::CCP_INIT: begin
				st_nxt.scan_en = 1'b1;
				// mode only moves here; later pin changes are ignored
				if (startup_gate && !st_r.gate_d) begin
					st_nxt.mode = mode_pins;
					st_nxt.phase = ccp_pkg::CCP_CONFIG;
				end
			end
			ccp_pkg::CCP_CONFIG: begin
				if (load_done) begin
					st_nxt.phase = ccp_pkg::CCP_USER;
					st_nxt.scan_en = scan_selected;
				end
			end
			ccp_pkg::CCP_USER: begin
				st_nxt.scan_en = scan_selected;
			end
			default: begin
				st_nxt.phase = ccp_pkg::CCP_INIT;
			end
		endcase
		if (!reload_request_n) begin
			st_nxt.phase = ccp_pkg::CCP_INIT;
			st_nxt.restart = 1'b1;
			st_nxt.scan_rst = 1'b1;
			st_nxt.scan_en = 1'b1;
		end
		// pins are steered from the next phase so outputs change with it
		if (st_nxt.phase == ccp_pkg::CCP_USER) begin
			st_nxt.user = 1'b1;
			st_nxt.hwl_o = user_out[1];
			st_nxt.hwl_oe_n = user_oe_n[1];
			st_nxt.rs_o = user_out[2];
			st_nxt.rs_oe_n = user_oe_n[2];
			if (host_port_used) begin
				st_nxt.ba_o = !loader_busy;
				st_nxt.ba_oe_n = 1'b0;
			end else begin
				st_nxt.ba_o = user_out[0];
				st_nxt.ba_oe_n = user_oe_n[0];
			end
		end else begin
			st_nxt.user = 1'b0;
			st_nxt.hwl_o = 1'b1;
			st_nxt.hwl_oe_n = 1'b0;
			st_nxt.rs_o = strobe_n;
			st_nxt.rs_oe_n = !master_par;
			st_nxt.ba_o = is_periph(st_r.mode) && !loader_busy;
			st_nxt.ba_oe_n = !(st_r.phase == ccp_pkg::CCP_CONFIG && is_periph(st_r.mode));
		end
		st_nxt.rd_data = '0;
		if (st_r.phase == ccp_pkg::CCP_CONFIG && host_sel && host_rd &&
			st_r.mode == MODE_W'(`CCP_MODE_PERIPH_ASYNC)) begin
			st_nxt.rd_data[`CCP_TOP_BIT] = !loader_busy;
		end
		// far side must hold tck or tms high while loading without scan
		st_nxt.scan_bad = (st_r.phase == ccp_pkg::CCP_CONFIG) && !scan_selected &&
			!test_clk && !test_mode_sel;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_r <= '{phase: ccp_pkg::CCP_INIT, gate_d: 1'b0, mode: MODE_W'(`CCP_MODE_RST),
				scan_en: 1'b1, scan_rst: 1'b0, restart: 1'b0, ba_o: 1'b0, ba_oe_n: 1'b1,
				rd_data: '0, hwl_o: 1'b1, hwl_oe_n: 1'b0, rs_o: 1'b1, rs_oe_n: 1'b1,
				user: 1'b0, scan_bad: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cfg_mode = st_r.mode;
	assign scan_enable = st_r.scan_en;
	assign scan_reset = st_r.scan_rst;
	assign load_restart = st_r.restart;
	assign byte_accept_o = st_r.ba_o;
	assign byte_accept_oe_n = st_r.ba_oe_n;
	assign host_rd_data = st_r.rd_data;
	assign high_while_loading_o = st_r.hwl_o;
	assign high_while_loading_oe_n = st_r.hwl_oe_n;
	assign rd_strobe_o = st_r.rs_o;
	assign rd_strobe_oe_n = st_r.rs_oe_n;
	assign pins_user = st_r.user;
	assign scan_inputs_bad = st_r.scan_bad;

	sequence s_gate_rise;
		st_r.phase == ccp_pkg::CCP_INIT && startup_gate && !st_r.gate_d && reload_request_n;
	endsequence

	a_mode_capture: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_gate_rise |=> cfg_mode == $past(mode_pins))
		else $error("mode not captured on gate rise");
	a_mode_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(st_r.phase != ccp_pkg::CCP_INIT) |=> $stable(cfg_mode))
		else $error("captured mode changed");
	a_scan_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(pins_user && !scan_selected && reload_request_n) |=> !scan_enable)
		else $error("scan enabled after load");
	a_pins_user: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(st_r.phase == ccp_pkg::CCP_CONFIG && load_done && reload_request_n) |=> pins_user)
		else $error("pins not handed to user");
	a_flag_periph: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(st_r.phase == ccp_pkg::CCP_CONFIG && is_periph(cfg_mode) && !loader_busy &&
		reload_request_n && !load_done) |=> byte_accept_o && !byte_accept_oe_n)
		else $error("byte-accept flag missing");
	a_top_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(st_r.phase == ccp_pkg::CCP_CONFIG && host_sel && host_rd &&
		cfg_mode == MODE_W'(`CCP_MODE_PERIPH_ASYNC))
		|=> host_rd_data[`CCP_TOP_BIT] == !$past(loader_busy))
		else $error("top data bit wrong");
	a_loading_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!pins_user |-> high_while_loading_o && !high_while_loading_oe_n)
		else $error("loading indicator low while loading");
	a_user_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(pins_user && $past(pins_user) && !$past(host_port_used))
		|-> byte_accept_o == $past(user_out[0]))
		else $error("flag pin not user i/o");
	a_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!reload_request_n |=> load_restart && scan_reset && !pins_user ##1
		(st_r.phase == ccp_pkg::CCP_INIT || !reload_request_n))
		else $error("reload not honoured");
endmodule : ccp_config_pins

// ===== core/ccp_map.svh
/*
 * constants for the configuration-control pin block: mode codes, widths, reset values.
 * assumes inclusion by bare name from the package and the design modules.
 */
`ifndef CCP_MAP_SVH
`define CCP_MAP_SVH

`define CCP_MODE_W 4
`define CCP_MODE_RST 4'h0
`define CCP_MODE_MASTER_PAR 4'h2
`define CCP_MODE_PERIPH_SYNC 4'h5
`define CCP_MODE_PERIPH_ASYNC 4'h7
`define CCP_DATA_W 8
`define CCP_TOP_BIT 7
`define CCP_RD_LOW_CYC 4'h2

`endif

// ===== core/ccp_pkg.sv
/*
 * types for the configuration-control pin block.
 * assumes ccp_map.svh is on the include path.
 */
`include "ccp_map.svh"

package ccp_pkg;
	typedef enum logic [1:0] {CCP_INIT, CCP_CONFIG, CCP_USER} ccp_phase_t;
	typedef logic [`CCP_MODE_W-1:0] ccp_mode_t;
endpackage : ccp_pkg

// ===== core/ccp_rd_strobe.sv
/*
 * read strobe generator towards an external configuration memory (master parallel mode).
 * assumes a request pulse from the loader; one request per strobe.
 */
`timescale 1ns/1ps
`include "ccp_map.svh"

module ccp_rd_strobe (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // synchronous reset, active high
	input wire logic enable, // master parallel mode while loading
	input wire logic req, // one-cycle request for a memory read
	output logic rd_strobe_n // read strobe, active low
);
	typedef struct packed {
		logic [3:0] cnt;
		logic rd_n;
	} ccp_rd_state_t;

	ccp_rd_state_t st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (st_r.cnt != 4'h0) begin
			st_nxt.cnt = st_r.cnt - 4'h1;
			if (st_r.cnt == 4'h1) begin
				st_nxt.rd_n = 1'b1;
			end
		end else if (enable && req) begin
			st_nxt.cnt = `CCP_RD_LOW_CYC;
			st_nxt.rd_n = 1'b0;
		end
		if (!enable) begin
			st_nxt.cnt = 4'h0;
			st_nxt.rd_n = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_r <= '{cnt: 4'h0, rd_n: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_strobe_n = st_r.rd_n;

	sequence s_strobe_pulse;
		!rd_strobe_n [*2] ##1 rd_strobe_n;
	endsequence

	a_strobe_width: assert property (@(posedge clk_sys) disable iff (sys_rst)
		($fell(rd_strobe_n) && enable) |-> s_strobe_pulse)
		else $error("read strobe width wrong");
endmodule : ccp_rd_strobe

// ===== tb/ccp_mem_model.sv
/*
 * model of the external configuration memory and idle scan controller.
 * assumes the strobe pin is sampled on clk_sys; counts driven-low cycles summed over all strobes.
 */
`timescale 1ns/1ps

module ccp_mem_model (
	input wire logic clk_sys, // system clock
	input wire logic rd_strobe_o, // strobe pin level from the device
	input wire logic rd_strobe_oe_n, // strobe pin enable, active low
	output logic test_clk, // scan clock pin, idle high
	output logic test_mode_sel, // scan mode select pin
	output int low_cnt // driven-low strobe cycles summed since start, never cleared
);
	// scan unused: both pins parked high so the device never sees a tap walk
	assign test_clk = 1'b1;
	assign test_mode_sel = 1'b1;
	// one driver for the count: the clocked process owns it, the port only mirrors it
	int cnt_q = 0;
	assign low_cnt = cnt_q;
	always @(posedge clk_sys) begin
		if (rd_strobe_oe_n === 1'b0 && rd_strobe_o === 1'b0) begin
			cnt_q <= cnt_q + 1;
		end
	end
endmodule : ccp_mem_model

// ===== tb/config_control_pins_test.sv
/*
 * self-checking bench for ccp_config_pins with the memory model on the strobe pin.
 * assumes registered outputs one cycle after the sampled cause.
 */
`timescale 1ns/1ps

module config_control_pins_test;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic reload_n = 1'b1, gate = 1'b0, done = 1'b0, busy = 1'b1, mreq = 1'b0;
	logic sel = 1'b0, rd = 1'b0, scan_sel = 1'b0, port_used = 1'b0;
	logic [3:0] mode = 4'h0, uo = 4'h5, uoe_n = 4'ha;
	logic tck, tms, bao, bao_n, hwl, hwl_n, rso, rso_n, pu, srst, lrst, sen, sib;
	logic [3:0] cfg_mode;
	logic [7:0] rdat;
	int low_cnt, num_errors = 0, n_tests = 0, cycles = 0;

	always #5 clk_sys = ~clk_sys;

	ccp_config_pins i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reload_request_n(reload_n),
		.startup_gate(gate), .mode_pins(mode), .load_done(done), .loader_busy(busy),
		.mem_read_req(mreq), .host_sel(sel), .host_rd(rd), .scan_selected(scan_sel),
		.host_port_used(port_used), .test_clk(tck), .test_mode_sel(tms), .user_out(uo),
		.user_oe_n(uoe_n), .cfg_mode(cfg_mode), .scan_enable(sen), .scan_reset(srst),
		.load_restart(lrst), .byte_accept_o(bao), .byte_accept_oe_n(bao_n),
		.host_rd_data(rdat), .high_while_loading_o(hwl), .high_while_loading_oe_n(hwl_n),
		.rd_strobe_o(rso), .rd_strobe_oe_n(rso_n), .pins_user(pu), .scan_inputs_bad(sib));
	ccp_mem_model i_mem (.clk_sys(clk_sys), .rd_strobe_o(rso), .rd_strobe_oe_n(rso_n),
		.test_clk(tck), .test_mode_sel(tms), .low_cnt(low_cnt));

	task step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step

	task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// restart, then capture a mode on a fresh gate rise
	task start(input logic [3:0] m);
		gate = 1'b0;
		reload_n = 1'b0;
		step(1);
		reload_n = 1'b1;
		chk("load_restart", 8'(lrst), 8'h01);
		chk("scan_reset", 8'(srst), 8'h01);
		mode = m;
		step(1);
		gate = 1'b1;
		step(2);
	endtask : start

	task t_capture();
		start(4'h2);
		chk("cfg_mode", 8'(cfg_mode), 8'h02);
		mode = 4'h7;
		step(3);
		chk("cfg_mode held", 8'(cfg_mode), 8'h02);
		chk("loading pin", 8'({hwl, hwl_n}), 8'h02);
		chk("scan_enable", 8'(sen), 8'h01);
		chk("scan pins bad", 8'(sib), 8'h00);
		$display("test capture done");
	endtask : t_capture

	task t_strobe();
		int base;
		base = low_cnt;
		mreq = 1'b1;
		step(1);
		mreq = 1'b0;
		step(1);
		chk("strobe low", 8'(rso), 8'h00);
		chk("strobe driven", 8'(rso_n), 8'h00);
		step(7);
		chk("strobe low cycles", 8'(low_cnt - base), 8'h02);
		chk("strobe idle", 8'(rso), 8'h01);
		$display("test strobe done");
	endtask : t_strobe

	// peripheral modes: flag in both, status bit only in the asynchronous one
	task t_periph(input logic [3:0] m, input logic [7:0] top_exp);
		start(m);
		busy = 1'b0;
		sel = 1'b1;
		rd = 1'b1;
		step(2);
		chk("flag ready", 8'({bao, bao_n}), 8'h02);
		chk("status read", rdat, top_exp);
		chk("strobe undriven", 8'(rso_n), 8'h01);
		busy = 1'b1;
		step(2);
		chk("flag busy", 8'(bao), 8'h00);
		chk("status busy", rdat, 8'h00);
		sel = 1'b0;
		rd = 1'b0;
		$display("test periph %h done", m);
	endtask : t_periph

	task t_done();
		done = 1'b1;
		step(2);
		chk("pins_user", 8'(pu), 8'h01);
		chk("scan off", 8'(sen), 8'h00);
		chk("loading user", 8'({hwl, hwl_n}), 8'({uo[1], uoe_n[1]}));
		chk("flag user", 8'({bao, bao_n}), 8'({uo[0], uoe_n[0]}));
		chk("strobe user", 8'({rso, rso_n}), 8'({uo[2], uoe_n[2]}));
		done = 1'b0;
		scan_sel = 1'b1;
		port_used = 1'b1;
		busy = 1'b0;
		step(2);
		chk("scan kept", 8'(sen), 8'h01);
		chk("flag host port", 8'({bao, bao_n}), 8'h02);
		scan_sel = 1'b0;
		port_used = 1'b0;
		busy = 1'b1;
		uo = 4'ha;
		uoe_n = 4'h5;
		step(2);
		chk("scan off again", 8'(sen), 8'h00);
		chk("flag user again", 8'({bao, bao_n}), 8'({uo[0], uoe_n[0]}));
		$display("test done pins done");
	endtask : t_done

	task test_done();
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done

	// hang guard: the whole run needs well under a few hundred cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			test_done();
		end
	end

	initial begin
		repeat (12) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		t_capture();
		t_strobe();
		t_periph(4'h7, 8'h80);
		t_periph(4'h5, 8'h00);
		t_done();
		test_done();
	end
endmodule : config_control_pins_test
